// File: include/csacr_pkg.sv
// Constants and types shared by the current-sense amplifier control register bank
package csacr_pkg;

  // Register addresses on the serial register interface
  localparam logic [3:0] ADDR_GATE_HS = 4'h3;
  localparam logic [3:0] ADDR_GATE_LS = 4'h4;
  localparam logic [3:0] ADDR_AMP_CFG = 4'h6;

  // Register width and frame shape
  localparam int REG_W = 11;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] ADDR_DONE_BITS = 5'h05;

  // Field positions
  localparam int AMP_SEL_BIT = 10;
  localparam int LS_PATH_BIT = 8;
  localparam int LOCK_MSB = 10;
  localparam int LOCK_LSB = 8;

  // Write lock codes
  localparam logic [2:0] LOCK_ENGAGE = 3'h6;
  localparam logic [2:0] LOCK_RELEASE = 3'h3;

  // Reset values
  localparam logic [10:0] AMP_CFG_RST = 11'h283;
  localparam logic [7:0] GATE_HS_DRIVE_RST = 8'hFF;
  localparam logic [10:0] GATE_LS_RST = 11'h7FF;

  // Amplifier configuration, laid out exactly as the register bits 10..0
  typedef struct packed {
    logic amp_input_select;
    logic ref_half_div;
    logic lowside_measure_path;
    logic [1:0] amp_gain_code;
    logic sense_fault_disable;
    logic offset_cal_channel_a;
    logic offset_cal_channel_b;
    logic offset_cal_channel_c;
    logic [1:0] sense_trip_level;
  } csacr_amp_cfg_type;

  // Gate drive settings presented to the driver stage
  typedef struct packed {
    logic retry_autoclear; // Fault clears itself on the next drive input
    logic [1:0] drive_time; // Peak gate-current drive time code
    logic [3:0] hs_source;
    logic [3:0] hs_sink;
    logic [3:0] ls_source;
    logic [3:0] ls_sink;
  } csacr_gate_type;

  // One serial frame, most significant bit first
  typedef struct packed {
    logic read;
    logic [3:0] addr;
    logic [10:0] data;
  } csacr_frame_type;

endpackage

// File: logic/csacr_reg_bank.sv
// Current-sense amplifier control register with gate drive and write lock registers
//
// Overview of operation
// - Amplifier config at 0x06, only with amplifiers
// - Bit 10 selects input; 1 forces bit 8
// - Bit 9 picks full or half reference
// - Bit 8 picks low-side measurement path
// - Bits 7-6 set gain, reset 10b
// - Bit 5 set disables sense fault
// - Bits 4-2 short channels for calibration
// - Bits 1-0 set trip level, reset 11b
// - Gate strengths by register or single pin
// - Lock 110b blocks writes; 011b unlocks
module csacr_reg_bank
  import csacr_pkg::*;
#(
  parameter bit HAS_AMP = 1'b1, // Variant carries the shunt amplifiers
  parameter bit HW_VARIANT = 1'b0 // Variant takes gate strength from a pin
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Serial register interface
  input wire logic sclk_in,
  input wire logic scs_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  // Pin-configured gate strength
  input wire logic [3:0] gate_strength_pin_in,
  // Configuration toward the analog blocks
  output csacr_amp_cfg_type amp_cfg_out,
  output csacr_gate_type gate_cfg_out,
  output logic write_locked_out
);

  // Whole state of the bank
  typedef struct packed {
    csacr_amp_cfg_type amp;
    logic locked;
    logic [7:0] hs_drive;
    logic [10:0] ls_reg;
    csacr_gate_type gate;
  } csacr_bank_state_type;

  csacr_bank_state_type st_r; // Registered state
  csacr_bank_state_type st_nxt; // Next state

  logic [3:0] lookup_addr; // Address under read
  logic [10:0] rd_data; // Read word for that address
  logic frame_done; // Whole frame received
  csacr_frame_type frame; // Its contents
  logic sdo_w; // Slave's registered output
  logic sdo_oe_w; // Slave's registered enable

  // Read view of one address; unmapped addresses read zero
  function automatic logic [10:0] read_word(input logic [3:0] addr, input csacr_bank_state_type s);
    logic [10:0] w;
    w = 11'h000;
    case (addr)
      ADDR_GATE_HS: w = {(s.locked ? LOCK_ENGAGE : LOCK_RELEASE), s.hs_drive};
      ADDR_GATE_LS: w = s.ls_reg;
      ADDR_AMP_CFG: w = HAS_AMP ? s.amp : 11'h000;
      default: w = 11'h000;
    endcase
    return w;
  endfunction

  assign rd_data = read_word(lookup_addr, st_r);

  // Frame receiver
  csacr_spi_slave u_spi (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .sclk_in(sclk_in),
    .scs_n_in(scs_n_in),
    .sdi_in(sdi_in),
    .sdo_out(sdo_w),
    .sdo_oe_out(sdo_oe_w),
    .lookup_addr_out(lookup_addr),
    .rd_data_in(rd_data),
    .frame_done_out(frame_done),
    .frame_out(frame)
  );

  // Register writes, lock handling and gate setting selection
  always_comb
  begin
    st_nxt = st_r;
    if (frame_done && !frame.read)
    begin
      case (frame.addr)
        ADDR_GATE_HS:
        begin
          // Lock field is always decoded; other codes change nothing
          if (!st_r.locked && frame.data[LOCK_MSB:LOCK_LSB] == LOCK_ENGAGE)
          begin
            st_nxt.locked = 1'b1;
          end
          else if (st_r.locked && frame.data[LOCK_MSB:LOCK_LSB] == LOCK_RELEASE)
          begin
            st_nxt.locked = 1'b0;
          end
          if (!st_r.locked)
          begin
            st_nxt.hs_drive = frame.data[7:0];
          end
        end
        ADDR_GATE_LS:
        begin
          if (!st_r.locked)
          begin
            st_nxt.ls_reg = frame.data;
          end
        end
        ADDR_AMP_CFG:
        begin
          // Whole word stored: reference, path, gain, fault, calibration, trip level
          if (!st_r.locked && HAS_AMP)
          begin
            st_nxt.amp = frame.data;
            if (frame.data[AMP_SEL_BIT])
            begin
              st_nxt.amp.lowside_measure_path = 1'b1;
            end
          end
        end
        default:
        begin
          // Other addresses belong to other blocks
        end
      endcase
    end
    // Gate settings: the pin variant drives source and sink from one code
    st_nxt.gate.retry_autoclear = st_r.ls_reg[10];
    st_nxt.gate.drive_time = st_r.ls_reg[9:8];
    if (HW_VARIANT)
    begin
      st_nxt.gate.hs_source = gate_strength_pin_in;
      st_nxt.gate.hs_sink = gate_strength_pin_in;
      st_nxt.gate.ls_source = gate_strength_pin_in;
      st_nxt.gate.ls_sink = gate_strength_pin_in;
    end
    else
    begin
      st_nxt.gate.hs_source = st_r.hs_drive[7:4];
      st_nxt.gate.hs_sink = st_r.hs_drive[3:0];
      st_nxt.gate.ls_source = st_r.ls_reg[7:4];
      st_nxt.gate.ls_sink = st_r.ls_reg[3:0];
    end
  end

  // State register; gate outputs settle one cycle after a write
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      st_r.amp <= AMP_CFG_RST;
      st_r.locked <= 1'b0;
      st_r.hs_drive <= GATE_HS_DRIVE_RST;
      st_r.ls_reg <= GATE_LS_RST;
      st_r.gate <= {GATE_LS_RST[10:8], GATE_HS_DRIVE_RST, GATE_LS_RST[7:0]};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign amp_cfg_out = st_r.amp;
  assign gate_cfg_out = st_r.gate;
  assign write_locked_out = st_r.locked;
  assign sdo_out = sdo_w;
  assign sdo_oe_out = sdo_oe_w;

  // Checks
  sequence s_amp_write;
    frame_done && !frame.read && frame.addr == ADDR_AMP_CFG && !st_r.locked;
  endsequence

  sequence s_hs_write;
    frame_done && !frame.read && frame.addr == ADDR_GATE_HS;
  endsequence

  a_amp_reset_value: assert property (@(posedge clk_in) !resetn_in |=> st_r.amp == AMP_CFG_RST)
    else $error("amp config not at reset value");

  a_input_forces_path: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_amp_write ##0 (HAS_AMP && frame.data[AMP_SEL_BIT]) |=> amp_cfg_out.lowside_measure_path && amp_cfg_out.amp_input_select)
    else $error("input select did not force measurement path");

  a_path_rewritable: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_amp_write ##0 (HAS_AMP && !frame.data[AMP_SEL_BIT])
    |=> amp_cfg_out.lowside_measure_path == $past(frame.data[LS_PATH_BIT]))
    else $error("measurement path not taken from write");

  a_amp_fields_store: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_amp_write ##0 HAS_AMP |=> amp_cfg_out[7:0] == $past(frame.data[7:0]) && amp_cfg_out[9] == $past(frame.data[9]))
    else $error("amp config fields not stored");

  a_locked_ignores: assert property (@(posedge clk_in) disable iff (!resetn_in)
    frame_done && !frame.read && st_r.locked && frame.addr != ADDR_GATE_HS |=> $stable(st_r.amp) && $stable(st_r.ls_reg))
    else $error("write accepted while locked");

  a_lock_engage: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_hs_write ##0 (!st_r.locked && frame.data[LOCK_MSB:LOCK_LSB] == LOCK_ENGAGE) |=> write_locked_out [*2])
    else $error("lock not engaged");

  a_lock_release: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_hs_write ##0 st_r.locked |=> write_locked_out == ($past(frame.data[LOCK_MSB:LOCK_LSB]) != LOCK_RELEASE))
    else $error("lock release decoded wrongly");

  a_absent_amp_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !HAS_AMP && lookup_addr == ADDR_AMP_CFG |-> rd_data == 11'h000)
    else $error("absent amplifier register reads nonzero");

  a_pin_gate_code: assert property (@(posedge clk_in) disable iff (!resetn_in)
    HW_VARIANT |=> gate_cfg_out.hs_source == $past(gate_strength_pin_in) && gate_cfg_out.ls_sink == $past(gate_strength_pin_in))
    else $error("pin gate strength not applied");

endmodule // csacr_reg_bank

// File: logic/csacr_spi_slave.sv
// Serial frame receiver and read-data shifter for the register bank
module csacr_spi_slave
  import csacr_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Serial pins, sampled on clk_in
  input wire logic sclk_in,
  input wire logic scs_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  // Read lookup toward the register bank
  output logic [3:0] lookup_addr_out,
  input wire logic [10:0] rd_data_in,
  // Completed frame
  output logic frame_done_out,
  output csacr_frame_type frame_out
);

  // Whole state of the receiver
  typedef struct packed {
    logic sclk_d;
    logic scs_n_d;
    logic [4:0] bit_cnt;
    csacr_frame_type shift;
    logic [10:0] tx;
    logic sdo;
    logic sdo_oe;
    logic done;
    csacr_frame_type frame;
  } csacr_spi_state_type;

  csacr_spi_state_type st_r; // Registered state
  csacr_spi_state_type st_nxt; // Next state

  // Address is complete together with the fifth captured bit
  assign lookup_addr_out = {st_r.shift[2:0], sdi_in};

  // Data captured on falling sclk, driven on rising sclk
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sclk_d = sclk_in;
    st_nxt.scs_n_d = scs_n_in;
    st_nxt.done = 1'b0;
    if (scs_n_in)
    begin
      // Idle: release the output, accept only whole frames
      st_nxt.sdo_oe = 1'b0;
      st_nxt.sdo = 1'b0;
      if (!st_r.scs_n_d && st_r.bit_cnt == FRAME_BITS)
      begin
        st_nxt.done = 1'b1;
        st_nxt.frame = st_r.shift;
      end
    end
    else if (st_r.scs_n_d)
    begin
      // Frame start
      st_nxt.bit_cnt = 5'h00;
      st_nxt.sdo_oe = 1'b1;
      st_nxt.sdo = 1'b0;
      st_nxt.tx = 11'h000;
    end
    else
    begin
      // Falling edge: capture, extra bits beyond a frame are dropped
      if (!sclk_in && st_r.sclk_d && st_r.bit_cnt != FRAME_BITS)
      begin
        st_nxt.shift = {st_r.shift[14:0], sdi_in};
        st_nxt.bit_cnt = 5'(st_r.bit_cnt + 5'h01);
        if (st_r.bit_cnt == 5'(ADDR_DONE_BITS - 5'h01))
        begin
          st_nxt.tx = rd_data_in;
        end
      end
      // Rising edge: next read bit, zeros before the data
      if (sclk_in && !st_r.sclk_d)
      begin
        st_nxt.sdo = st_r.tx[10];
        st_nxt.tx = {st_r.tx[9:0], 1'b0};
      end
    end
  end

  // State register
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign sdo_out = st_r.sdo;
  assign sdo_oe_out = st_r.sdo_oe;
  assign frame_done_out = st_r.done;
  assign frame_out = st_r.frame;

endmodule // csacr_spi_slave

// File: sim/csacr_host_model.sv
// Host controller model that drives serial register frames into the device
module csacr_host_model
  import csacr_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Serial pins toward the device
  output logic sclk_out,
  output logic scs_n_out,
  output logic sdi_out,
  // Read data back from the device
  input wire logic sdo_in,
  input wire logic sdo_oe_in
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus: deselected, serial clock parked low
  initial
  begin
    sclk_out = 1'b0;
    scs_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  // One frame of nbits clocks; the last 11 bits seen on sdo form the read data
  task automatic xfer(input logic rd, input logic [3:0] addr, input logic [10:0] data, input int nbits,
                      output logic [10:0] rdata, output logic oe_seen);
    csacr_frame_type f;
    f = '{read: rd, addr: addr, data: data};
    rdata = '0;
    oe_seen = 1'b1;
    @(negedge clk_in);
    scs_n_out = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      // Data leads the serial clock by a whole phase so capture never races it
      sdi_out = f[15 - i];
      @(negedge clk_in);
      sclk_out = 1'b1;
      repeat (2) @(negedge clk_in);
      rdata = {rdata[9:0], sdo_in};
      oe_seen = oe_seen & sdo_oe_in;
      // Falling edge: the device captures sdi here
      sclk_out = 1'b0;
      repeat (2) @(negedge clk_in);
    end
    scs_n_out = 1'b1;
    // Released data line must not keep looking like valid data
    sdi_out = ~sdi_out;
    // Covers the write latency and the gap between frames
    repeat (4) @(negedge clk_in);
  endtask
endmodule // csacr_host_model

// File: sim/csacr_reg_bank_test.sv
// Self-checking bench for the amplifier control register bank
module csacr_reg_bank_test
  import csacr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_in; // Bench clock
  logic resetn_in; // Active-low reset
  logic sclk, scs_n, sdi, sdo, sdo_oe; // Serial pins
  logic [3:0] gate_pin; // Strength pin, read only by the pin-configured variant
  csacr_amp_cfg_type amp_cfg_pin; // Settings of the variant without amplifiers
  csacr_gate_type gate_cfg_pin; // Gate settings of the pin-configured variant
  csacr_amp_cfg_type amp_cfg; // Amplifier settings
  csacr_gate_type gate_cfg; // Gate drive settings
  logic locked; // Write lock state
  logic [10:0] rd; // Last read data
  logic oe; // Drive enable seen through a frame
  int n_fail = 0;
  int samples_checked = 0;
  logic [10:0] vals [5] = '{11'h000, 11'h07D, 11'h2AA, 11'h1D5, 11'h0E2}; // Mixed field patterns

  // Clock at 10 MHz
  always #50 clk_in = ~clk_in;

  csacr_reg_bank #(.HAS_AMP(1'b1), .HW_VARIANT(1'b0)) dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .sclk_in(sclk), .scs_n_in(scs_n), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .gate_strength_pin_in(gate_pin), .amp_cfg_out(amp_cfg), .gate_cfg_out(gate_cfg),
    .write_locked_out(locked));

  csacr_host_model host (.clk_in(clk_in), .sclk_out(sclk), .scs_n_out(scs_n), .sdi_out(sdi),
    .sdo_in(sdo), .sdo_oe_in(sdo_oe));

  // Second variant on the same frames: no amplifiers, gate strength from the pin
  csacr_reg_bank #(.HAS_AMP(1'b0), .HW_VARIANT(1'b1)) dut_pin (.clk_in(clk_in), .resetn_in(resetn_in),
    .sclk_in(sclk), .scs_n_in(scs_n), .sdi_in(sdi), .sdo_out(), .sdo_oe_out(),
    .gate_strength_pin_in(gate_pin), .amp_cfg_out(amp_cfg_pin), .gate_cfg_out(gate_cfg_pin),
    .write_locked_out());

  // Verdict and end of run
  task automatic conclude();
    if (n_fail == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Compare a register-wide value
  task automatic chk_word(input logic [10:0] got, input logic [10:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
      n_fail++;
    end
  endtask

  // Compare a single flag
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    chk_word({10'h000, got}, {10'h000, exp}, msg);
  endtask

  // Register write frame
  task automatic wr(input logic [3:0] addr, input logic [10:0] data);
    host.xfer(1'b0, addr, data, 16, rd, oe);
  endtask

  // Register read frame with expected data; sdo must be driven throughout
  task automatic rdr(input logic [3:0] addr, input logic [10:0] exp);
    host.xfer(1'b1, addr, 11'h000, 16, rd, oe);
    chk_word(rd, exp, "read data");
    chk_bit(oe, 1'b1, "sdo drive");
  endtask

  // A hung run still reaches the verdict
  initial
  begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    conclude();
  end

  // Main sequence
  initial
  begin
    clk_in = 1'b0;
    resetn_in = 1'b0;
    gate_pin = 4'h0;
    repeat (4) @(negedge clk_in);
    resetn_in = 1'b1;
    chk_bit(amp_cfg.ref_half_div, 1'b1, "reset ref");
    chk_bit(amp_cfg.lowside_measure_path, 1'b0, "reset path");
    chk_word({9'h000, amp_cfg.amp_gain_code}, 11'h002, "reset gain");
    chk_bit(amp_cfg.sense_fault_disable, 1'b0, "reset disable");
    chk_word({8'h00, amp_cfg.offset_cal_channel_a, amp_cfg.offset_cal_channel_b,
              amp_cfg.offset_cal_channel_c}, 11'h000, "reset cal");
    chk_word({9'h000, amp_cfg.sense_trip_level}, 11'h003, "reset trip");
    chk_bit(locked, 1'b0, "reset lock");
    chk_word({3'h0, gate_cfg.hs_source, gate_cfg.hs_sink}, {3'h0, GATE_HS_DRIVE_RST}, "reset hs gate");
    rdr(ADDR_AMP_CFG, AMP_CFG_RST);
    chk_bit(sdo_oe, 1'b0, "sdo released");
    chk_word({3'h0, gate_cfg_pin.hs_source, gate_cfg_pin.ls_sink}, 11'h000, "pin code zero");
    // Every gain code, trip codes 00b, 01b and 10b, each flag but input select both ways
    foreach (vals[i])
    begin
      wr(ADDR_AMP_CFG, vals[i]);
      chk_word(amp_cfg, vals[i], "cfg write");
      rdr(ADDR_AMP_CFG, vals[i]);
    end
    // Input select forces the path bit, which then stays software-owned
    wr(ADDR_AMP_CFG, 11'h4C0);
    chk_word(amp_cfg, 11'h5C0, "path forced");
    wr(ADDR_AMP_CFG, 11'h100);
    chk_word(amp_cfg, 11'h100, "path kept");
    wr(ADDR_AMP_CFG, 11'h000);
    chk_bit(amp_cfg.lowside_measure_path, 1'b0, "path cleared");
    // Lock, try a refused write and a wrong code, then unlock
    wr(ADDR_GATE_HS, {LOCK_ENGAGE, 8'h3C});
    chk_bit(locked, 1'b1, "lock engaged");
    rdr(ADDR_GATE_HS, {LOCK_ENGAGE, 8'h3C});
    wr(ADDR_AMP_CFG, 11'h155);
    chk_word(amp_cfg, 11'h000, "locked write");
    wr(ADDR_GATE_HS, {3'h5, 8'h00});
    chk_bit(locked, 1'b1, "wrong unlock");
    wr(ADDR_GATE_HS, {LOCK_RELEASE, 8'h00});
    chk_bit(locked, 1'b0, "unlocked");
    chk_word({3'h0, gate_cfg.hs_source, gate_cfg.hs_sink}, 11'h03C, "hs strength");
    wr(ADDR_GATE_LS, 11'h2A5);
    chk_word({gate_cfg.retry_autoclear, gate_cfg.drive_time, gate_cfg.ls_source, gate_cfg.ls_sink}, 11'h2A5,
             "ls gate");
    wr(ADDR_AMP_CFG, 11'h155);
    chk_word(amp_cfg, 11'h155, "unlocked write");
    gate_pin = 4'h9;
    // A short frame is dropped; an unmapped address reads zero
    host.xfer(1'b0, ADDR_AMP_CFG, 11'h0AA, 15, rd, oe);
    chk_word(amp_cfg, 11'h155, "short frame");
    rdr(4'hF, 11'h000);
    rdr(ADDR_GATE_HS, {LOCK_RELEASE, 8'h3C});
    chk_word(amp_cfg_pin, AMP_CFG_RST, "absent amp kept");
    chk_word({3'h0, gate_cfg_pin.hs_source, gate_cfg_pin.hs_sink}, 11'h099, "pin hs strength");
    chk_word({3'h0, gate_cfg_pin.ls_source, gate_cfg_pin.ls_sink}, 11'h099, "pin ls strength");
    conclude();
  end
endmodule // csacr_reg_bank_test
